// ---- hw/csp_pkg.sv ----
// Shared constants and types for the card socket power sequencer
package csp_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned OFF_TIME_MS  = 1000;
  localparam int unsigned RDY_TIME_MS  = 400;
  localparam logic [31:0] OFF_CYC_DFLT = 32'(OFF_TIME_MS * (CLK_HZ / 1000));
  localparam logic [31:0] RDY_CYC_DFLT = 32'(RDY_TIME_MS * (CLK_HZ / 1000));

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQS_OFS = 8'h08;
  localparam logic [7:0] IRQM_OFS = 8'h0c;
  localparam logic [7:0] OFFC_OFS = 8'h10;
  localparam logic [7:0] RDYC_OFS = 8'h14;

  localparam int unsigned CTRL_AUTO_BIT  = 0;
  localparam int unsigned CTRL_CYCLE_BIT = 1;
  localparam logic        CTRL_AUTO_RST  = 1'h1;

  localparam int unsigned STAT_INS_BIT  = 0;
  localparam int unsigned STAT_PWR_BIT  = 1;
  localparam int unsigned STAT_RDY_BIT  = 2;
  localparam int unsigned STAT_DIAG_BIT = 3;
  localparam int unsigned STAT_ACT_BIT  = 4;

  localparam int unsigned EVT_W   = 3;
  localparam logic [3:0]  PIN_RST = 4'h3;

  typedef struct packed {
    logic ready;
    logic removed;
    logic inserted;
  } csp_evt_t;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_OFF,
    ST_SETTLE,
    ST_READY
  } csp_state_t;
endpackage : csp_pkg

// ---- hw/csp_sequencer.sv ----
// Card socket power sequencer with AHB-Lite register slave
// What this block does
// - Bridge may omit 8-bit and 16-bit select
// - Insertion valid only when both detects low
// - Repeat power cycle on every reinsertion
// - Socket power output is active low
// - After reset, switch socket power on
// - On insertion, power off about one second
// - Bridge may identify devices, then set modes
// - Wait 400 ms by default (RDYC register can change it), then flag card ready
`timescale 1ns/100ps
module csp_sequencer
#(
  parameter logic [31:0] OFF_CYCLES = csp_pkg::OFF_CYC_DFLT,
  parameter logic [31:0] RDY_CYCLES = csp_pkg::RDY_CYC_DFLT
)
(
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        card_detect_a_i,
  input  wire logic        card_detect_b_i,
  input  wire logic        diag_monitor_i,
  input  wire logic        active_monitor_i,
  output logic             socket_power_n_o,
  output logic             irq_o
);
  import csp_pkg::*;

  logic [3:0]         pin_q1;
  logic [3:0]         pin_q2;
  logic [3:0]         pin_q3;
  logic [3:0]         pin_state;
  logic               ins;
  logic               ins_d;
  csp_state_t         state;
  logic [31:0]        timer;
  logic               ctrl_auto;
  logic               cyc_req;
  logic [EVT_W-1:0]   irq_status;
  logic [EVT_W-1:0]   irq_mask;
  logic [31:0]        off_count;
  logic [31:0]        rdy_count;
  logic               wr_pend;
  logic [7:0]         wr_addr;
  logic               rdy_d;
  csp_evt_t           evt;
  logic [EVT_W-1:0]   irq_clr;
  logic               addr_ok;
  logic [31:0]        next_rdata;

  // Pin synchroniser, value accepted when stages two and three agree
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      pin_q1    <= PIN_RST;
      pin_q2    <= PIN_RST;
      pin_q3    <= PIN_RST;
      pin_state <= PIN_RST;
    end
    else
    begin
      pin_q1 <= {active_monitor_i, diag_monitor_i, card_detect_b_i, card_detect_a_i};
      pin_q2 <= pin_q1;
      pin_q3 <= pin_q2;
      if (pin_q2 == pin_q3)
      begin
        pin_state <= pin_q3;
      end
    end
  end

  // Both detects low means fully inserted
  assign ins = ~pin_state[0] & ~pin_state[1];

  // Sequencer
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_BOOT;
      timer <= 32'h0;
    end
    else
    begin
      unique case (state)
        ST_BOOT:
        begin
          state <= ST_IDLE;
          timer <= 32'h0;
        end
        ST_IDLE:
        begin
          if (ins && (ctrl_auto || cyc_req))
          begin
            state <= ST_OFF;
            timer <= 32'h0;
          end
        end
        ST_OFF:
        begin
          if (!ins)
          begin
            state <= ST_IDLE;
          end
          else if (timer + 32'h1 >= off_count)
          begin
            state <= ST_SETTLE;
            timer <= 32'h0;
          end
          else
          begin
            timer <= timer + 32'h1;
          end
        end
        ST_SETTLE:
        begin
          if (!ins)
          begin
            state <= ST_IDLE;
          end
          else if (timer + 32'h1 >= rdy_count)
          begin
            state <= ST_READY;
            timer <= 32'h0;
          end
          else
          begin
            timer <= timer + 32'h1;
          end
        end
        ST_READY:
        begin
          if (!ins)
          begin
            state <= ST_IDLE;
          end
          else if (cyc_req)
          begin
            state <= ST_OFF;
            timer <= 32'h0;
          end
        end
      endcase
    end
  end

  // Socket supply, low drives power on
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      socket_power_n_o <= 1'h1;
    end
    else
    begin
      socket_power_n_o <= (state == ST_BOOT) || (state == ST_OFF);
    end
  end

  // Events and sticky interrupt status, set wins over clear
  assign evt.inserted = ins & ~ins_d;
  assign evt.removed  = ~ins & ins_d;
  assign evt.ready    = (state == ST_READY) & ~rdy_d;
  assign irq_clr      = (wr_pend && wr_addr == IRQS_OFS) ? hwdata_i[EVT_W-1:0] : '0;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      ins_d      <= 1'h0;
      rdy_d      <= 1'h0;
      irq_status <= '0;
      irq_o      <= 1'h0;
    end
    else
    begin
      ins_d      <= ins;
      rdy_d      <= (state == ST_READY);
      irq_status <= (irq_status & ~irq_clr) | evt;
      irq_o      <= |(irq_status & irq_mask);
    end
  end

  // Bus address phase, word access only, size not decoded
  assign addr_ok = hsel_i && htrans_i[1] && hready_i;

  always_comb
  begin
    next_rdata = 32'h0;
    unique case (haddr_i[7:0])
      CTRL_OFS: next_rdata[CTRL_AUTO_BIT] = ctrl_auto;
      STAT_OFS:
      begin
        next_rdata[STAT_INS_BIT]  = ins;
        next_rdata[STAT_PWR_BIT]  = ~socket_power_n_o;
        next_rdata[STAT_RDY_BIT]  = (state == ST_READY);
        next_rdata[STAT_DIAG_BIT] = pin_state[2];
        next_rdata[STAT_ACT_BIT]  = pin_state[3];
      end
      IRQS_OFS: next_rdata[EVT_W-1:0] = irq_status;
      IRQM_OFS: next_rdata[EVT_W-1:0] = irq_mask;
      OFFC_OFS: next_rdata = off_count;
      RDYC_OFS: next_rdata = rdy_count;
      default:  next_rdata = 32'h0;
    endcase
    if (haddr_i[31:8] != 24'h0)
    begin
      next_rdata = 32'h0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'h1;
      hresp_o     <= 1'h0;
      wr_pend     <= 1'h0;
      wr_addr     <= 8'h0;
    end
    else
    begin
      hreadyout_o <= 1'h1;
      hresp_o     <= 1'h0;
      wr_pend     <= addr_ok && hwrite_i && (haddr_i[31:8] == 24'h0);
      wr_addr     <= haddr_i[7:0];
      if (addr_ok && !hwrite_i)
      begin
        hrdata_o <= next_rdata;
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_auto <= CTRL_AUTO_RST;
      cyc_req   <= 1'h0;
      irq_mask  <= '0;
      off_count <= OFF_CYCLES;
      rdy_count <= RDY_CYCLES;
    end
    else
    begin
      cyc_req <= 1'h0;
      if (wr_pend)
      begin
        unique case (wr_addr)
          CTRL_OFS:
          begin
            ctrl_auto <= hwdata_i[CTRL_AUTO_BIT];
            cyc_req   <= hwdata_i[CTRL_CYCLE_BIT];
          end
          IRQM_OFS: irq_mask  <= hwdata_i[EVT_W-1:0];
          OFFC_OFS: off_count <= hwdata_i;
          RDYC_OFS: rdy_count <= hwdata_i;
          default:  ;
        endcase
      end
    end
  end

  // Checks
  a_insert_both_low: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (state == ST_IDLE && !ins) |=> (state != ST_OFF))
    else $error("power cycle started without full insertion");

  a_reinsert_cycle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (state == ST_IDLE && ins && ctrl_auto) |=> (state == ST_OFF) ##1 socket_power_n_o)
    else $error("insertion did not start a power cycle");

  a_boot_power_on: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> ##[1:3] !socket_power_n_o)
    else $error("socket power not applied after reset");

  a_off_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (state == ST_OFF && ins && timer + 32'h1 < off_count) |=> (state == ST_OFF) ##1 socket_power_n_o)
    else $error("power off interval cut short");

  a_off_end: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (state == ST_OFF ##1 state == ST_SETTLE) |-> ($past(timer) + 32'h1 >= off_count))
    else $error("power off ended before terminal count");

  a_rearm_remove: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (state inside {ST_OFF, ST_SETTLE, ST_READY} && !ins) |=> (state == ST_IDLE))
    else $error("removal did not re-arm the sequencer");

  a_ready_wait: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (state == ST_SETTLE ##1 state == ST_READY) |-> ($past(timer) + 32'h1 >= rdy_count))
    else $error("card reported ready too early");

  a_power_on_low: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (state == ST_READY) |=> !socket_power_n_o)
    else $error("socket power not low while card ready");

  a_irq_level: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (|(irq_status & irq_mask)) |=> irq_o)
    else $error("unmasked event did not raise interrupt");

  a_bus_okay: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !hresp_o && hreadyout_o)
    else $error("bus response not OKAY and ready");
endmodule : csp_sequencer

// ---- verification/csp_card_model.sv ----
// Behavioural storage card at the socket
`timescale 1ns/100ps
module csp_card_model
#(
  parameter logic STRAP = 1'h0,
  parameter logic CSEL  = 1'h0
)
(
  input  wire logic       core_clk_i,
  input  wire logic       socket_power_n_i,
  input  wire logic [1:0] present_i,
  input  wire logic [1:0] drive_i,
  output logic            card_detect_a_o,
  output logic            card_detect_b_o,
  output logic            diag_o,
  output logic            active_o,
  output logic            native_o,
  output logic            master_o
);
  logic prev_n = 1'h1;
  logic native = 1'h0;
  logic live;
  assign live            = ~socket_power_n_i & (&present_i);
  assign card_detect_a_o = ~present_i[0];
  assign card_detect_b_o = ~present_i[1];
  assign diag_o          = live ? drive_i[0] : 1'h1;
  assign active_o        = live ? drive_i[1] : 1'h1;
  assign master_o        = ~CSEL;
  assign native_o        = native;
  always_ff @(posedge core_clk_i)
  begin
    prev_n <= socket_power_n_i;
    if (socket_power_n_i | ~(&present_i))
      native <= 1'h0;
    else if (prev_n)
      native <= ~STRAP;
  end
endmodule : csp_card_model

// ---- verification/card_socket_power_sequencer_test.sv ----
// Self-checking bench for the socket power sequencer
`timescale 1ns/100ps
module card_socket_power_sequencer_test;
  import csp_pkg::*;
  localparam logic [31:0] OFFP = 32'h14;
  localparam logic [31:0] RDYP = 32'ha;
  logic        clk, rst, hsel, hwrite, hready, hresp, pwr_n, irq, cda, cdb, diag, act, native;
  logic [1:0]  htrans, present, drv;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, offc;
  int          n_mismatch, total_checks, n;
  csp_sequencer #(.OFF_CYCLES(OFFP), .RDY_CYCLES(RDYP)) u_csp_sequencer (
    .core_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .card_detect_a_i(cda), .card_detect_b_i(cdb),
    .diag_monitor_i(diag), .active_monitor_i(act), .socket_power_n_o(pwr_n), .irq_o(irq));
  csp_card_model u_csp_card_model (
    .core_clk_i(clk), .socket_power_n_i(pwr_n), .present_i(present), .drive_i(drv),
    .card_detect_a_o(cda), .card_detect_b_o(cdb), .diag_o(diag), .active_o(act),
    .native_o(native), .master_o());
  function automatic logic [31:0] exp_stat(logic i, logic p, logic r, logic [1:0] m);
    return {27'h0, m[1], m[0], r, p, i};
  endfunction : exp_stat
  function automatic logic [31:0] exp_cnt(logic [31:0] c);
    return (c == 32'h0) ? 32'h1 : c;
  endfunction : exp_cnt
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'h1)
      @(posedge clk);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'h1)
      @(posedge clk);
    rd = hrdata;
    chk("hresp", hresp, 32'h0);
  endtask : ahb
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'h0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rchk
  task waitv(input logic v, input int lim);
    n = 0;
    while (pwr_n !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk("power wait", 32'(n < lim), 32'h1);
  endtask : waitv
  task off_len(input logic [31:0] exp);
    waitv(1'h1, 50);
    n = 0;
    while (pwr_n === 1'h1 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    chk("off length", 32'(n), exp);
  endtask : off_len
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial
  begin
    clk = 1'h0;
    forever
      #5 clk = ~clk;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    {rst, hsel, hwrite, htrans, haddr, hwdata, present, drv} = '0;
    rst   = 1'h1;
    hsize = 3'h2;
    rd    = $urandom(32'h0fef);
    repeat (4)
      @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1 chk("power boot", pwr_n, 32'h1);
    @(posedge clk);
    #1 chk("power up", pwr_n, 32'h0);
    @(posedge clk);
    rchk("ctrl", CTRL_OFS, 32'h1);
    rchk("mask", IRQM_OFS, 32'h0);
    rchk("offc", OFFC_OFS, OFFP);
    rchk("rdyc", RDYC_OFS, RDYP);
    rchk("unmapped", 8'h18, 32'h0);
    rchk("stat", STAT_OFS, exp_stat(1'h0, 1'h1, 1'h0, 2'h3));
    ahb(1'h1, IRQM_OFS, 32'h7);
    $display("reset test done");
    drv     <= 2'($urandom);
    present <= 2'h3;
    off_len(OFFP);
    repeat (4)
      @(posedge clk);
    rchk("stat", STAT_OFS, exp_stat(1'h1, 1'h1, 1'h0, drv));
    repeat (RDYP)
      @(posedge clk);
    rchk("irqs", IRQS_OFS, 32'h5);
    chk("irq", irq, 32'h1);
    chk("native", native, 32'h1);
    ahb(1'h1, IRQS_OFS, 32'h5);
    rchk("irqs clr", IRQS_OFS, 32'h0);
    chk("irq clr", irq, 32'h0);
    $display("insert test done");
    present <= 2'h2;
    repeat (40)
      @(posedge clk);
    rchk("irqs", IRQS_OFS, 32'h2);
    chk("power", pwr_n, 32'h0);
    ahb(1'h1, IRQS_OFS, 32'h7);
    $display("half test done");
    for (int k = 0; k < 4; k++)
    begin
      offc = (k == 0) ? 32'h0 : $urandom_range(40, 1);
      ahb(1'h1, OFFC_OFS, offc);
      present <= 2'h3;
      off_len(exp_cnt(offc));
      repeat (RDYP + 4)
        @(posedge clk);
      present <= 2'h0;
      repeat (8)
        @(posedge clk);
    end
    ahb(1'h1, IRQS_OFS, 32'h7);
    ahb(1'h1, OFFC_OFS, OFFP);
    $display("reinsert test done");
    present <= 2'h3;
    waitv(1'h1, 50);
    repeat (3)
      @(posedge clk);
    present <= 2'h0;
    waitv(1'h0, 8);
    rchk("irqs", IRQS_OFS, 32'h3);
    ahb(1'h1, IRQS_OFS, 32'h7);
    ahb(1'h1, IRQM_OFS, 32'h0);
    ahb(1'h1, CTRL_OFS, 32'h0);
    ahb(1'h1, OFFC_OFS, OFFP);
    present <= 2'h3;
    repeat (40)
      @(posedge clk);
    chk("manual hold", pwr_n, 32'h0);
    rchk("ctrl", CTRL_OFS, 32'h0);
    ahb(1'h1, CTRL_OFS, 32'h2);
    off_len(OFFP);
    repeat (RDYP + 4)
      @(posedge clk);
    chk("irq masked", irq, 32'h0);
    ahb(1'h0, IRQS_OFS, 32'h0);
    chk("ready flag", rd[2], 32'h1);
    ahb(1'h1, IRQM_OFS, 32'h4);
    repeat (2)
      @(posedge clk);
    chk("irq unmasked", irq, 32'h1);
    ahb(1'h1, CTRL_OFS, 32'h2);
    off_len(OFFP);
    $display("manual test done");
    end_sim();
  end
endmodule : card_socket_power_sequencer_test
